// [bench/bbt_pipe_model.sv]
`timescale 1ns/10ps
`default_nettype none
// stands in for the fetch and load/store pipeline of the hart
module bbt_pipe_model (
  input  wire logic             mclk,
  output var bbt_pkg::bbt_req_s fetch_req,
  output var bbt_pkg::bbt_req_s data_req
);
  import bbt_pkg::*;

  // both streams start idle so nothing is taken during reset
  initial begin
    fetch_req = '0;
    data_req  = '0;
  end

  // one request per call, valid for exactly one edge
  task automatic issue(input logic f, input logic [NWW-1:0] va, input logic [1:0] pv);
    bbt_req_s r;
    r = '{valid: 1'b1, vaddr: va, priv: pv};
    @(posedge mclk);
    if (f)
      fetch_req <= r;
    else
      data_req <= r;
    @(posedge mclk);
    // released address shows the inverse, never the last value; priv keeps its value
    r.valid = 1'b0;
    r.vaddr = ~va;
    if (f)
      fetch_req <= r;
    else
      data_req <= r;
  endtask
endmodule
`default_nettype wire

// [bench/test_base_bound_translation.sv]
`timescale 1ns/10ps
`default_nettype none
module test_base_bound_translation;
  import bbt_pkg::*;

  logic        mclk;               // 100 MHz hart clock
  logic        nrst;               // async reset, active low
  logic [2:0]  avs_address;        // register word index
  logic        avs_read;           // read strobe
  logic        avs_write;          // write strobe
  logic [31:0] avs_writedata;      // write data
  logic [3:0]  avs_byteenable;     // all lanes on every write
  logic [31:0] avs_readdata;       // read data
  logic        avs_waitrequest;    // slave stall
  bbt_req_s    fetch_req;          // fetch stream from the pipeline model
  bbt_req_s    data_req;           // load/store stream
  bbt_rsp_s    fetch_rsp;          // fetch answer
  bbt_rsp_s    data_rsp;           // load/store answer
  int          mismatches;         // failed comparisons
  int          checks_done;        // all comparisons
  // reference state: m[3..6] are the four segment registers
  logic [31:0] m [0:7];
  logic [1:0]  scheme;             // selected scheme
  logic        modify_privilege_flag;               // modify-privilege flag
  logic [1:0]  prior_privilege_field;                // prior-privilege field
  logic        sf;                 // sticky fetch fault
  logic        df;                 // sticky data fault
  logic [31:0] faddr;              // last faulting address

  bbt_top u_bbt_top (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fetch_req(fetch_req), .data_req(data_req),
    .fetch_rsp(fetch_rsp), .data_rsp(data_rsp));
  bbt_pipe_model u_bbt_pipe_model (.mclk(mclk), .fetch_req(fetch_req), .data_req(data_req));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // cuts a hang short; the whole run needs far fewer cycles
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_reg(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_xl(input string what, input bbt_rsp_s e, input bbt_rsp_s g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  // one avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    do begin
      @(negedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      complete_run();
    end
    rd = avs_readdata;
    @(posedge mclk);
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~wd;
  endtask

  // write and mirror the effect in the reference state
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, a, wd, rd);
    if (a == REG_CTRL) begin
      // value 3 names no scheme and is dropped
      if (wd[1:0] != 2'h3)
        scheme = wd[1:0];
      modify_privilege_flag = wd[2];
      prior_privilege_field  = wd[4:3];
      sf   = sf & !wd[8];
      df   = df & !wd[9];
    end else if (a == REG_SBASE || a == REG_SLIMIT) begin
      m[a+2] = wd;
      m[a+4] = wd;
    end else if (a != REG_FADDR)
      m[a] = wd;
  endtask

  task automatic rd_reg(input logic [2:0] a);
    logic [31:0] rd;
    logic [31:0] e;
    bus(1'b0, a, 32'h0, rd);
    e = (a == REG_CTRL) ? {22'h0, df, sf, 3'h0, prior_privilege_field, modify_privilege_flag, scheme} :
        (a == REG_FADDR) ? faddr : (a < 3) ? m[a+4] : m[a];
    cmp_reg($sformatf("reg %0d", a), e, rd);
  endtask

  // expected answer worked out from the scheme rules
  function automatic bbt_rsp_s expect_xl(input logic f, input logic [31:0] va,
                                         input logic [1:0] pv);
    logic [1:0]  ep;
    logic [31:0] off;
    logic        sp;
    bbt_rsp_s    r;
    ep = (!f && pv == PRIV_M && modify_privilege_flag) ? prior_privilege_field : pv;
    sp = f && scheme == BBT_SPLIT;
    off = va;
    r = '{valid: 1'b1, paddr: va, fault: 1'b0, vaddr: va};
    if (ep != PRIV_M && scheme != BBT_PASS) begin
      // split fetches live in the upper half and lose the top bit
      if (sp) begin
        r.fault = !va[31];
        off[31] = 1'b0;
      end
      if (off >= (sp ? m[4] : m[6]))
        r.fault = 1'b1;
      r.paddr = off + (sp ? m[3] : m[5]);
    end
    if (r.fault) begin
      r.valid = 1'b0;
      r.paddr = '0;
    end
    return r;
  endfunction

  // one translation, answer looked at in the cycle after it is taken
  task automatic xl(input logic f, input logic [31:0] va, input logic [1:0] pv);
    bbt_rsp_s e;
    bbt_rsp_s g;
    e = expect_xl(f, va, pv);
    u_bbt_pipe_model.issue(f, va, pv);
    @(negedge mclk);
    g = f ? fetch_rsp : data_rsp;
    // paddr is not compared on a fault; the design still drives the translated value
    if (e.fault)
      g.paddr = '0;
    cmp_xl(f ? "fetch_rsp" : "data_rsp", e, g);
    if (e.fault) begin
      faddr = va;
      sf = sf | f;
      df = df | !f;
    end
  endtask

  // select a scheme, then random traffic clustered on the limit edges
  task automatic run_mode(input logic [1:0] sv, input int n, input string nm);
    logic [31:0] r;
    logic [31:0] va;
    logic [31:0] l;
    r = $urandom;
    wr_reg(REG_CTRL, {22'h0, 2'h3, 3'h0, r[4:3], r[2], sv});
    for (int i = 0; i < n; i++) begin
      r = $urandom;
      l = (r[0] && scheme == BBT_SPLIT) ? m[4] : m[6];
      va = (r[4:3] == 0) ? $urandom : (r[4:3] == 1) ? l - 32'h1 : (r[4:3] == 2) ? l :
           l - 32'h1 - {24'h0, r[15:8]};
      if (r[0] && scheme == BBT_SPLIT)
        va[31] = r[6:5] != 2'h0;
      xl(r[0], va, r[2:1]);
    end
    rd_reg(REG_CTRL);
    if (sf | df)
      rd_reg(REG_FADDR);
    $display("test %s done: checks %0d mismatches %0d", nm, checks_done, mismatches);
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    foreach (m[i]) m[i] = SEG_RESET;
    {scheme, modify_privilege_flag, prior_privilege_field, sf, df, faddr} = '0;
    checks_done = 0;
    mismatches = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    void'($urandom(4077));
    for (int a = 0; a < 7; a++)
      rd_reg(a[2:0]);
    run_mode(BBT_PASS, 30, "pass");
    wr_reg(REG_SBASE, $urandom);
    wr_reg(REG_SLIMIT, $urandom);
    for (int a = 3; a < 7; a++)
      rd_reg(a[2:0]);
    run_mode(BBT_SINGLE, 60, "single");
    wr_reg(REG_DBASE, $urandom);
    wr_reg(REG_DLIMIT, $urandom);
    rd_reg(REG_SBASE);
    rd_reg(REG_SLIMIT);
    for (int a = 3; a < 7; a++)
      wr_reg(a[2:0], $urandom);
    run_mode(BBT_SPLIT, 80, "split");
    run_mode(2'h3, 20, "bad scheme");
    run_mode(BBT_SINGLE, 30, "back to single");
    run_mode(BBT_PASS, 20, "pass again");
    wr_reg(REG_FADDR, $urandom);
    rd_reg(REG_FADDR);
    $display("test registers done: checks %0d mismatches %0d", checks_done, mismatches);
    complete_run();
  end
endmodule
`default_nettype wire

// [src/bbt_pkg.sv]
package bbt_pkg;

  // native word and physical address widths
  localparam int NWW = 32;
  localparam int PAW = 32;

  // privilege encodings seen on the request ports
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_H = 2'h2;
  localparam logic [1:0] PRIV_M = 2'h3;

  // translation scheme field values
  typedef enum logic [1:0] {
    BBT_PASS   = 2'b00,
    BBT_SINGLE = 2'b01,
    BBT_SPLIT  = 2'b10
  } bbt_scheme_e;

  // register word indices on the avalon bus (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_SBASE  = 3'h1;
  localparam logic [2:0] REG_SLIMIT = 3'h2;
  localparam logic [2:0] REG_IBASE  = 3'h3;
  localparam logic [2:0] REG_ILIMIT = 3'h4;
  localparam logic [2:0] REG_DBASE  = 3'h5;
  localparam logic [2:0] REG_DLIMIT = 3'h6;
  localparam logic [2:0] REG_FADDR  = 3'h7;

  // control register field positions
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_MODIFY_PRIVILEGE_FLAG_BIT   = 2;
  localparam int CTRL_MPP_LSB    = 3;
  localparam int CTRL_SF_BIT     = 8;
  localparam int CTRL_DF_BIT     = 9;

  // reset values
  localparam logic [NWW-1:0] SEG_RESET = 32'h0000_0000;

  // one request from the fetch or load/store pipeline
  typedef struct packed {
    logic           valid;
    logic [NWW-1:0] vaddr;
    logic [1:0]     priv;
  } bbt_req_s;

  // one answer toward memory and the pipeline
  typedef struct packed {
    logic           valid;
    logic [PAW-1:0] paddr;
    logic           fault;
    logic [NWW-1:0] vaddr;
  } bbt_rsp_s;

  // result of one translation
  typedef struct packed {
    logic [PAW-1:0] paddr;
    logic           fault;
  } bbt_xl_s;

endpackage

// [src/bbt_top.sv]
// Function
// [RULE1] reset or scheme 0 gives pass-through
// [RULE2] pass-through copies address, drops excess bits
// [RULE3] scheme 1 selects single base/limit segment
// [RULE4] single segment starts at zero, maps at base
// [RULE5] lower-privilege addresses get base added
// [RULE6] fault when address at or above limit
// [RULE7] machine accesses bypass unless modify-privilege loads/stores
// [RULE8] scheme 2 selects split instruction/data segments
// [RULE9] split mode uses own base/limit per stream
// [RULE10] data at zero, instructions at top half
// [RULE11] split fetch with clear top bit faults
// [RULE12] split fetch top bit cleared for base/limit
// [RULE13] split support implies single support
// [RULE14] single base/limit writes update both copies
// [RULE15] single base/limit reads return data copy
// [RULE16] single mode fetch keeps top bit intact
// [RULE17] scheme only changed from machine register bus
// [RULE18] modify-privilege loads/stores use prior privilege
// [RULE19] faults precise, faulting access never reaches memory
`timescale 1ns/10ps
`default_nettype none
module bbt_top
  import bbt_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                nrst,
  // avalon-mm register slave, word addressed
  input  wire logic [2:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // pipeline side
  input  wire bbt_pkg::bbt_req_s   fetch_req,
  input  wire bbt_pkg::bbt_req_s   data_req,
  // memory side and fault reporting
  output bbt_pkg::bbt_rsp_s        fetch_rsp,
  output bbt_pkg::bbt_rsp_s        data_rsp
);
  import bbt_pkg::*;

  // control and segment state
  bbt_scheme_e    scheme_q;      // translation scheme field
  logic           modify_privilege_flag_q;        // modify-privilege flag
  logic [1:0]     mpp_q;         // prior-privilege field
  logic [NWW-1:0] ibase_q;       // instruction segment base
  logic [NWW-1:0] ilimit_q;      // instruction segment limit
  logic [NWW-1:0] dbase_q;       // data segment base
  logic [NWW-1:0] dlimit_q;      // data segment limit
  logic [NWW-1:0] faddr_q;       // last faulting virtual address
  logic           sfault_q;      // sticky fetch fault seen
  logic           dfault_q;      // sticky data fault seen

  // bus handshake state
  logic           ack_q;         // answer phase of the current access
  logic [31:0]    rdata_q;       // read data captured for the answer
  logic           bus_req;       // a read or write is pending
  logic           wr_take;       // write commits this edge

  // byte-lane merge, used by the four segment registers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // translate one address; shared by the fetch and data streams
  function automatic bbt_xl_s xlate(input logic [NWW-1:0] va,
                                    input logic           is_fetch,
                                    input logic [1:0]     epriv,
                                    input bbt_scheme_e    sch,
                                    input logic [NWW-1:0] ib,
                                    input logic [NWW-1:0] il,
                                    input logic [NWW-1:0] db,
                                    input logic [NWW-1:0] dl);
    bbt_xl_s        r;
    logic [NWW-1:0] off;
    r.paddr = va[PAW-1:0];                              // see [RULE2]
    r.fault = 1'b0;
    off     = va;
    if (epriv != PRIV_M) begin                          // see [RULE7]
      case (sch)
        BBT_SINGLE: begin
          // single mode: both copies hold the same value after a full-word alias write
          r.paddr = PAW'(db + va);                      // see [RULE4] see [RULE5] see [RULE16]
          r.fault = (va >= dl);                         // see [RULE6]
        end
        BBT_SPLIT: begin
          if (is_fetch) begin
            off     = {1'b0, va[NWW-2:0]};              // see [RULE12]
            r.paddr = PAW'(ib + off);                   // see [RULE9] see [RULE10]
            r.fault = !va[NWW-1] || (off >= il);        // see [RULE11]
          end else begin
            r.paddr = PAW'(db + va);                    // see [RULE9] see [RULE10]
            r.fault = (va >= dl);
          end
        end
        default: begin
          r.paddr = va[PAW-1:0];                        // see [RULE1]
          r.fault = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  // effective privileges: data may borrow the prior privilege
  logic [1:0] fetch_priv;
  logic [1:0] data_priv;
  bbt_xl_s    fetch_xl;
  bbt_xl_s    data_xl;

  always_comb begin
    fetch_priv = fetch_req.priv;                        // fetches never borrow
    data_priv  = data_req.priv;
    if (data_req.priv == PRIV_M && modify_privilege_flag_q) begin
      data_priv = mpp_q;                                // see [RULE18] see [RULE7]
    end
  end

  // both streams are translated and checked in the same cycle
  assign fetch_xl = xlate(fetch_req.vaddr, 1'b1, fetch_priv, scheme_q,
                          ibase_q, ilimit_q, dbase_q, dlimit_q);
  assign data_xl  = xlate(data_req.vaddr, 1'b0, data_priv, scheme_q,
                          ibase_q, ilimit_q, dbase_q, dlimit_q);

  // avalon handshake: one wait cycle, then the answer
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_q;
  assign wr_take         = avs_write && ack_q;
  assign avs_readdata    = rdata_q;

  // answer phase toggles once per access
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  // read data is captured in the wait cycle; unmapped reads are zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        REG_CTRL: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[CTRL_SCHEME_LSB +: 2] <= scheme_q;
          rdata_q[CTRL_MODIFY_PRIVILEGE_FLAG_BIT]        <= modify_privilege_flag_q;
          rdata_q[CTRL_MPP_LSB +: 2]    <= mpp_q;
          rdata_q[CTRL_SF_BIT]          <= sfault_q;
          rdata_q[CTRL_DF_BIT]          <= dfault_q;
        end
        REG_SBASE:  rdata_q <= dbase_q;                 // see [RULE15]
        REG_SLIMIT: rdata_q <= dlimit_q;                // see [RULE15]
        REG_IBASE:  rdata_q <= ibase_q;
        REG_ILIMIT: rdata_q <= ilimit_q;
        REG_DBASE:  rdata_q <= dbase_q;
        REG_DLIMIT: rdata_q <= dlimit_q;
        REG_FADDR:  rdata_q <= faddr_q;
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // control register; only this machine-level bus can change the scheme
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scheme_q <= BBT_PASS;                             // see [RULE1]
      modify_privilege_flag_q   <= 1'b0;
      mpp_q    <= PRIV_U;
    end else if (wr_take && avs_address == REG_CTRL && avs_byteenable[0]) begin
      // value 3 is not a scheme; keep the old one rather than fall back
      case (avs_writedata[CTRL_SCHEME_LSB +: 2])
        BBT_PASS:   scheme_q <= BBT_PASS;               // see [RULE1] see [RULE17]
        BBT_SINGLE: scheme_q <= BBT_SINGLE;             // see [RULE3] see [RULE13]
        BBT_SPLIT:  scheme_q <= BBT_SPLIT;              // see [RULE8]
        default:    scheme_q <= scheme_q;
      endcase
      modify_privilege_flag_q <= avs_writedata[CTRL_MODIFY_PRIVILEGE_FLAG_BIT];
      mpp_q  <= avs_writedata[CTRL_MPP_LSB +: 2];
    end
  end

  // instruction segment pair, written directly or through the alias
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ibase_q  <= SEG_RESET;
      ilimit_q <= SEG_RESET;
    end else if (wr_take) begin
      if (avs_address == REG_SBASE || avs_address == REG_IBASE) begin
        ibase_q <= be_merge(ibase_q, avs_writedata, avs_byteenable);   // see [RULE14]
      end
      if (avs_address == REG_SLIMIT || avs_address == REG_ILIMIT) begin
        ilimit_q <= be_merge(ilimit_q, avs_writedata, avs_byteenable); // see [RULE14]
      end
    end
  end

  // data segment pair, written directly or through the alias
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dbase_q  <= SEG_RESET;
      dlimit_q <= SEG_RESET;
    end else if (wr_take) begin
      if (avs_address == REG_SBASE || avs_address == REG_DBASE) begin
        dbase_q <= be_merge(dbase_q, avs_writedata, avs_byteenable);   // see [RULE14]
      end
      if (avs_address == REG_SLIMIT || avs_address == REG_DLIMIT) begin
        dlimit_q <= be_merge(dlimit_q, avs_writedata, avs_byteenable); // see [RULE14]
      end
    end
  end

  // fault bookkeeping: a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sfault_q <= 1'b0;
      dfault_q <= 1'b0;
      faddr_q  <= SEG_RESET;
    end else begin
      if (wr_take && avs_address == REG_CTRL && avs_byteenable[1]) begin
        // write one to clear the sticky bits
        if (avs_writedata[CTRL_SF_BIT]) sfault_q <= 1'b0;
        if (avs_writedata[CTRL_DF_BIT]) dfault_q <= 1'b0;
      end
      if (fetch_req.valid && fetch_xl.fault) begin
        sfault_q <= 1'b1;
        faddr_q  <= fetch_req.vaddr;
      end
      // data faults take the address register when both fault together
      if (data_req.valid && data_xl.fault) begin
        dfault_q <= 1'b1;
        faddr_q  <= data_req.vaddr;
      end
    end
  end

  // registered answers; a faulting access never asserts valid to memory
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fetch_rsp <= '0;
    end else begin
      fetch_rsp.valid <= fetch_req.valid && !fetch_xl.fault;   // see [RULE19]
      fetch_rsp.fault <= fetch_req.valid && fetch_xl.fault;    // see [RULE19]
      fetch_rsp.paddr <= fetch_xl.paddr;
      fetch_rsp.vaddr <= fetch_req.vaddr;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_rsp <= '0;
    end else begin
      data_rsp.valid <= data_req.valid && !data_xl.fault;      // see [RULE19]
      data_rsp.fault <= data_req.valid && data_xl.fault;       // see [RULE19]
      data_rsp.paddr <= data_xl.paddr;
      data_rsp.vaddr <= data_req.vaddr;
    end
  end

  // checks on the translation path and the register bus
  sequence fetch_low_split_s;
    fetch_req.valid && fetch_req.priv != PRIV_M && scheme_q == BBT_SPLIT;
  endsequence

  sequence data_low_single_s;
    data_req.valid && data_req.priv != PRIV_M && scheme_q == BBT_SINGLE;
  endsequence

  pass_through_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE2]
    (scheme_q == BBT_PASS && data_req.valid) |=>
      (data_rsp.valid && data_rsp.paddr == $past(data_req.vaddr)))
    else $error("pass-through changed the address");

  single_add_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE5]
    (data_low_single_s and (data_req.vaddr < dlimit_q) and !modify_privilege_flag_q) |=>
      (data_rsp.valid && data_rsp.paddr == PAW'($past(dbase_q) + $past(data_req.vaddr))))
    else $error("single segment address not base plus offset");

  limit_fault_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE6]
    (data_low_single_s and (data_req.vaddr >= dlimit_q)) |=>
      (data_rsp.fault && !data_rsp.valid))
    else $error("access at or above limit did not fault");

  machine_bypass_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE7]
    (fetch_req.valid && fetch_req.priv == PRIV_M) |=>
      (fetch_rsp.valid && fetch_rsp.paddr == $past(fetch_req.vaddr)))
    else $error("machine fetch was translated or checked");

  split_msb_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE11]
    (fetch_low_split_s and !fetch_req.vaddr[NWW-1]) |=> fetch_rsp.fault)
    else $error("split fetch below top half did not fault");

  split_fetch_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE12]
    (fetch_low_split_s and fetch_req.vaddr[NWW-1]
       and ({1'b0, fetch_req.vaddr[NWW-2:0]} < ilimit_q)) |=>
      (fetch_rsp.valid
       && fetch_rsp.paddr == PAW'($past(ibase_q) + {1'b0, $past(fetch_req.vaddr[NWW-2:0])})))
    else $error("split fetch not mapped through instruction segment");

  borrow_priv_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE18]
    (data_req.valid && data_req.priv == PRIV_M && modify_privilege_flag_q && mpp_q != PRIV_M
       && scheme_q == BBT_SINGLE && data_req.vaddr >= dlimit_q) |=> data_rsp.fault)
    else $error("borrowed privilege access was not checked");

  no_fault_mem_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE19]
    !(fetch_rsp.valid && fetch_rsp.fault) && !(data_rsp.valid && data_rsp.fault))
    else $error("faulting access reached memory");

  alias_write_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE14]
    (wr_take && avs_address == REG_SBASE && avs_byteenable == 4'hf) |=>
      (ibase_q == $past(avs_writedata) && dbase_q == $past(avs_writedata)))
    else $error("alias base write did not reach both copies");

  bus_answer_a: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_req && !ack_q) |=> (!bus_req || !avs_waitrequest))
    else $error("bus answer later than one wait cycle");

  scheme_reset_a: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE1]
    (wr_take && avs_address == REG_CTRL && avs_byteenable[0]
       && avs_writedata[1:0] == 2'b00) |=> scheme_q == BBT_PASS)
    else $error("writing zero did not select pass-through");

endmodule
`default_nettype wire
